// ### route_pkg.sv
// Shared constants and carrier types for the modulator, timer and converter routing
package route_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] SRC_OFFSET = 8'h04;
  localparam logic [7:0] SWCTL_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam int ADDR_BITS = 8;

  // Control register field positions
  localparam int TIMER3_INPUT_SELECT_BIT = 0;
  localparam int CONV_MODE_LSB = 1;

  // Source select register: two bits per complementary pair
  localparam int SRC_PAIR_WIDTH = 2;
  localparam int PAIR_COUNT = 3;
  localparam int OUTPUT_COUNT = 6;

  // Software control register: low six bits are mode, next six the forced values
  localparam int SWCTL_MODE_LSB = 0;
  localparam int SWCTL_VALUE_LSB = 6;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SRC_RESET = 32'h0000_0000;
  localparam logic [31:0] SWCTL_RESET = 32'h0000_0000;

  // Converter limit comparison result width
  localparam int RESULT_WIDTH = 12;

  typedef enum logic [1:0] {
    SRC_GENERATOR = 2'h0,
    SRC_PORT = 2'h1,
    SRC_TIMER = 2'h2,
    SRC_CONVERTER = 2'h3
  } source_type;

  typedef enum logic [1:0] {
    MODE_SEQUENTIAL = 2'h0,
    MODE_SIMULTANEOUS = 2'h1,
    MODE_PARALLEL_INDEPENDENT = 2'h2
  } conv_mode_type;

  // Inputs from the peripheral blocks around the router
  typedef struct packed {
    logic [5:0] generator;
    logic [3:0] timer_out;
    logic [2:0] port_b_lines;
    logic [2:0] limit_high;
    logic [2:0] limit_low;
  } sources_type;

  typedef struct packed {
    logic converter_a_start;
    logic converter_b_start;
  } conv_start_type;

endpackage : route_pkg

// ### limit_waveform.sv
// Converts converter over/under-limit flags into held waveform levels
`timescale 1ns/1ps
`default_nettype none
module limit_waveform (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [2:0] limit_high,
  input wire logic [2:0] limit_low,
  output logic [2:0] wave
);

  logic [2:0] wave_reg;

  // Level holds between the limits; high limit takes priority
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wave_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (limit_high[i]) begin
          wave_reg[i] <= 1'b0;
        end else if (limit_low[i]) begin
          wave_reg[i] <= 1'b1;
        end
      end
    end
  end

  assign wave = wave_reg;

endmodule : limit_waveform
`default_nettype wire

// ### ahb_regs.sv
// AHB-Lite slave holding the routing control registers
`timescale 1ns/1ps
`default_nettype none
module ahb_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] status,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] ctrl,
  output logic [31:0] src,
  output logic [31:0] swctl
);

  logic [31:0] ctrl_reg;
  logic [31:0] src_reg;
  logic [31:0] swctl_reg;
  logic [31:0] hrdata_reg;
  logic wr_pending_reg;
  logic [7:0] wr_addr_reg;
  logic take;

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] c,
                                           input logic [31:0] s, input logic [31:0] w,
                                           input logic [31:0] st);
    if (a == route_pkg::CTRL_OFFSET) begin
      read_mux = c;
    end else if (a == route_pkg::SRC_OFFSET) begin
      read_mux = s;
    end else if (a == route_pkg::SWCTL_OFFSET) begin
      read_mux = w;
    end else if (a == route_pkg::STATUS_OFFSET) begin
      read_mux = st;
    end else begin
      read_mux = 32'h0000_0000;
    end
  endfunction : read_mux

  // Zero wait states; unmapped addresses read zero and ignore writes
  assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pending_reg <= take && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata_reg <= read_mux(haddr[7:0], ctrl_reg, src_reg, swctl_reg, status);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= route_pkg::CTRL_RESET;
      src_reg <= route_pkg::SRC_RESET;
      swctl_reg <= route_pkg::SWCTL_RESET;
    end else if (wr_pending_reg) begin
      if (wr_addr_reg == route_pkg::CTRL_OFFSET) begin
        ctrl_reg <= {29'h0, hwdata[2:0]};
      end else if (wr_addr_reg == route_pkg::SRC_OFFSET) begin
        src_reg <= {26'h0, hwdata[5:0]};
      end else if (wr_addr_reg == route_pkg::SWCTL_OFFSET) begin
        swctl_reg <= {20'h0, hwdata[11:0]};
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ctrl = ctrl_reg;
  assign src = src_reg;
  assign swctl = swctl_reg;

endmodule : ahb_regs
`default_nettype wire

// ### trigger_route.sv
// Routing of modulator reload, timer outputs and converter triggers, with alternate pair sources
//
// Behaviour
// - Modulator reload pulse can serve as timer channel 3 input.
// - One control bit chooses whether reload pulse feeds timer channel 3.
// - Timer 3 output drives master trigger; timer 2 drives second trigger.
// - Sequential or simultaneous mode: master trigger starts both converters.
// - Parallel independent: second trigger starts converter B, master starts A.
// - Alternate source only when both pair channels software-controlled with values 1.
// - Port source: line two to outputs 0,1; three to 2; four to 4,5.
// - Timer source: timer 0 to outputs 0,1; 2 to 2; 3 to 4,5.
// - Converter source: sample 0 to outputs 0,1; 1 to 2; 2 to 4,5.
// - Limit waveform goes low above high limit, high below low limit.
// - Modulator generator stays selectable for every pair.
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module trigger_route (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reload_pulse,
  input wire logic timer3_pin_input,
  input wire route_pkg::sources_type sources,
  output logic timer3_input,
  output logic adc_master_trigger,
  output logic adc_second_trigger,
  output route_pkg::conv_start_type conv_start,
  output logic [5:0] pwm_out
);

  logic [31:0] ctrl;
  logic [31:0] src;
  logic [31:0] swctl;
  logic [31:0] status;
  logic [2:0] port_adc_second_trigger_reg;
  logic [2:0] port_sync2_reg;
  logic [2:0] limit_wave;
  logic timer3_input_select;
  route_pkg::conv_mode_type conv_mode;
  logic [5:0] sw_mode;
  logic [5:0] sw_value;
  logic [2:0] pair_alt;
  logic [2:0] pair_wave;
  logic [5:0] pwm_next;
  logic [5:0] pwm_reg;
  logic master_reg;
  logic second_reg;
  route_pkg::conv_start_type conv_start_reg;

  ahb_regs u_regs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .status(status),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ctrl(ctrl),
    .src(src),
    .swctl(swctl)
  );

  limit_waveform u_limit (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .limit_high(sources.limit_high),
    .limit_low(sources.limit_low),
    .wave(limit_wave)
  );

  // Port lines come from pins and need synchronising
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      port_adc_second_trigger_reg <= 3'h0;
      port_sync2_reg <= 3'h0;
    end else begin
      port_adc_second_trigger_reg <= sources.port_b_lines;
      port_sync2_reg <= port_adc_second_trigger_reg;
    end
  end

  assign timer3_input_select = ctrl[route_pkg::TIMER3_INPUT_SELECT_BIT];
  assign conv_mode = route_pkg::conv_mode_type'(ctrl[route_pkg::CONV_MODE_LSB +: 2]);
  assign sw_mode = swctl[route_pkg::SWCTL_MODE_LSB +: route_pkg::OUTPUT_COUNT];
  assign sw_value = swctl[route_pkg::SWCTL_VALUE_LSB +: route_pkg::OUTPUT_COUNT];

  // Timer channel 3 input mux is combinational so the reload edge is not delayed
  assign timer3_input = timer3_input_select ? reload_pulse : timer3_pin_input;

  // Triggers registered so converters see clean copies of the timer outputs, one cycle later and as wide as the timer pulses
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      master_reg <= 1'b0;
      second_reg <= 1'b0;
    end else begin
      master_reg <= sources.timer_out[3];
      second_reg <= sources.timer_out[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_start_reg <= '0;
    end else begin
      conv_start_reg.converter_a_start <= sources.timer_out[3];
      case (conv_mode)
        route_pkg::MODE_PARALLEL_INDEPENDENT: begin
          conv_start_reg.converter_b_start <= sources.timer_out[2];
        end
        default: begin
          conv_start_reg.converter_b_start <= sources.timer_out[3];
        end
      endcase
    end
  end

  assign adc_master_trigger = master_reg;
  assign adc_second_trigger = second_reg;
  assign conv_start = conv_start_reg;

  function automatic logic pick(input logic [1:0] sel, input logic gen, input logic port,
                                input logic tmr, input logic lim);
    case (sel)
      route_pkg::SRC_PORT: pick = port;
      route_pkg::SRC_TIMER: pick = tmr;
      route_pkg::SRC_CONVERTER: pick = lim;
      default: pick = gen;
    endcase
  endfunction : pick

  // Pair index maps to outputs 2p and 2p+1, except pair 1, which drives output 2 only
  always_comb begin
    for (int p = 0; p < route_pkg::PAIR_COUNT; p++) begin
      pair_alt[p] = &sw_mode[2*p +: 2] && &sw_value[2*p +: 2];
    end
    pair_wave[0] = pick(src[1:0], sources.generator[0], port_sync2_reg[0],
                        sources.timer_out[0], limit_wave[0]);
    pair_wave[1] = pick(src[3:2], sources.generator[2], port_sync2_reg[1],
                        sources.timer_out[2], limit_wave[1]);
    pair_wave[2] = pick(src[5:4], sources.generator[4], port_sync2_reg[2],
                        sources.timer_out[3], limit_wave[2]);
    pwm_next = sources.generator;
    // Generator source keeps the pair's own complementary waveforms, not one copied twice
    if (pair_alt[0] && (src[1:0] != route_pkg::SRC_GENERATOR)) begin
      pwm_next[1:0] = {2{pair_wave[0]}};
    end
    // Only output 2 of the middle pair takes the alternate waveform
    if (pair_alt[1]) begin
      pwm_next[2] = pair_wave[1];
    end
    if (pair_alt[2] && (src[5:4] != route_pkg::SRC_GENERATOR)) begin
      pwm_next[5:4] = {2{pair_wave[2]}};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_reg <= 6'h00;
    end else begin
      pwm_reg <= pwm_next;
    end
  end

  assign pwm_out = pwm_reg;
  assign status = {23'h0, limit_wave, pair_alt, pwm_reg[2:0]};

endmodule : trigger_route
`default_nettype wire

// ### far_side_model.sv
// Far-side model: modulator, timer and converter outputs on the system clock
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire route_pkg::sources_type set_value,
  input wire logic reload_req,
  output var route_pkg::sources_type sources,
  output logic reload_pulse
);
  // Peripheral outputs leave their own flops, so they move just after an edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sources <= '0;
    end else begin
      sources <= set_value;
    end
  end
  // One pulse per reload, never a held level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reload_pulse <= 1'b0;
    end else begin
      reload_pulse <= reload_req && !reload_pulse;
    end
  end
endmodule : far_side_model
`default_nettype wire

// ### route_props.sv
// Port checker for the routing block
`timescale 1ns/1ps
`default_nettype none
module route_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reload_pulse,
  input wire logic timer3_pin_input,
  input wire route_pkg::sources_type sources,
  input wire logic timer3_input,
  input wire logic adc_master_trigger,
  input wire logic adc_second_trigger,
  input wire route_pkg::conv_start_type conv_start,
  input wire logic [5:0] pwm_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_master;
    $past(rstn) |-> adc_master_trigger == $past(sources.timer_out[3]);
  endproperty
  a_master: assert property (p_master) else $error("master trigger lost timer 3");
  property p_second;
    $past(rstn) |-> adc_second_trigger == $past(sources.timer_out[2]);
  endproperty
  a_second: assert property (p_second) else $error("second trigger lost timer 2");
  property p_conv_a;
    $past(rstn) |-> conv_start.converter_a_start == $past(sources.timer_out[3]);
  endproperty
  a_conv_a: assert property (p_conv_a) else $error("converter a start wrong");
  property p_conv_b;
    $past(rstn) && $past(sources.timer_out[2]) == $past(sources.timer_out[3])
      |-> conv_start.converter_b_start == $past(sources.timer_out[3]);
  endproperty
  a_conv_b: assert property (p_conv_b) else $error("converter b start wrong");
  property p_t3;
    reload_pulse == timer3_pin_input |-> timer3_input == reload_pulse;
  endproperty
  a_t3: assert property (p_t3) else $error("timer 3 input not from a source");
  property p_out3;
    $past(rstn) |-> pwm_out[3] == $past(sources.generator[3]);
  endproperty
  a_out3: assert property (p_out3) else $error("output 3 left generator");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_pair;
    adc_master_trigger |-> conv_start.converter_a_start;
  endproperty
  a_pair: assert property (p_pair) else $error("master trigger without a start");
  c_pulse: cover property (reload_pulse && timer3_input);
  c_indep: cover property (conv_start.converter_b_start && !conv_start.converter_a_start);
  c_alt: cover property ($rose(pwm_out[4]));
endmodule : route_props
bind trigger_route route_props props (.clk_sys, .rstn, .hreadyout, .hresp, .reload_pulse,
  .timer3_pin_input, .sources, .timer3_input, .adc_master_trigger, .adc_second_trigger,
  .conv_start, .pwm_out);
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the routing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, timer3_input, adc_master_trigger, adc_second_trigger, reload_pulse;
  logic timer3_pin_input = 1'b0;
  logic reload_req = 1'b0;
  route_pkg::sources_type set_value = '0;
  route_pkg::sources_type sources;
  route_pkg::conv_start_type conv_start;
  logic [5:0] pwm_out;
  int bad_count = 0;
  int compares = 0;
  logic [5:0] mask [3] = '{6'h03, 6'h04, 6'h30};
  int tidx [3] = '{0, 2, 3};
  far_side_model far (.clk_sys, .rstn, .set_value, .reload_req, .sources, .reload_pulse);
  trigger_route dut (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .reload_pulse, .timer3_pin_input,
    .sources, .timer3_input, .adc_master_trigger, .adc_second_trigger, .conv_start, .pwm_out);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        bad_count++;
        finish_test();
      end
      @(posedge clk_sys);
    end
  endtask : wait_ready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask : settle
  task automatic t_regs();
    rd(route_pkg::CTRL_OFFSET, route_pkg::CTRL_RESET);
    rd(route_pkg::SRC_OFFSET, route_pkg::SRC_RESET);
    rd(route_pkg::SWCTL_OFFSET, route_pkg::SWCTL_RESET);
    wr(route_pkg::CTRL_OFFSET, 32'h5);
    rd(route_pkg::CTRL_OFFSET, 32'h5);
    rd(8'h40, 32'h0);
  endtask : t_regs
  task automatic t_trig3();
    for (int s = 0; s < 2; s++) begin
      wr(route_pkg::CTRL_OFFSET, 32'(s));
      reload_req <= 1'b1;
      @(posedge clk_sys);
      reload_req <= 1'b0;
      #1;
      `CHK(timer3_input, 1'(s))
      @(posedge clk_sys);
      timer3_pin_input <= 1'b1;
      #1;
      `CHK(timer3_input, 1'(1 - s))
      @(posedge clk_sys);
      timer3_pin_input <= 1'b0;
    end
  endtask : t_trig3
  task automatic t_conv();
    logic [1:0] v;
    for (int m = 0; m < 3; m++) begin
      wr(route_pkg::CTRL_OFFSET, 32'(m << 1));
      for (int i = 1; i < 3; i++) begin
        v = 2'(i);
        set_value <= {6'h0, v, 2'h0, 9'h0};
        settle();
        `CHK(adc_master_trigger, v[1])
        `CHK(adc_second_trigger, v[0])
        `CHK(conv_start.converter_a_start, v[1])
        `CHK(conv_start.converter_b_start, (m == 2) ? v[0] : v[1])
      end
    end
  endtask : t_conv
  task automatic t_pairs();
    set_value <= {6'h2a, 13'h0};
    wr(route_pkg::SWCTL_OFFSET, 32'hfff);
    wr(route_pkg::SRC_OFFSET, 32'h0);
    settle();
    `CHK(pwm_out, 6'h2a)
    for (int s = 1; s < 4; s++) begin
      wr(route_pkg::SRC_OFFSET, 32'(s * 21));
      for (int k = 0; k < 3; k++) begin
        if (s == 1) set_value <= {10'h0, 3'(1 << k), 6'h0};
        else if (s == 2) set_value <= {6'h0, 4'(1 << tidx[k]), 9'h0};
        else begin
          // Held limit level must be cleared before the next sample is set
          set_value <= {13'h0, 3'h7, 3'h0};
          settle();
          set_value <= {16'h0, 3'(1 << k)};
        end
        settle();
        `CHK(pwm_out, mask[k])
      end
    end
    set_value <= {16'h0, 3'h7};
    settle();
    `CHK(pwm_out, 6'h37)
    wr(route_pkg::SWCTL_OFFSET, 32'hfbf);
    settle();
    `CHK(pwm_out, 6'h34)
    set_value <= {13'h0, 3'h7, 3'h0};
    wr(route_pkg::SWCTL_OFFSET, 32'hfff);
    settle();
    `CHK(pwm_out, 6'h00)
    // Status: outputs 2..0 low, all pairs on alternate source, limit levels low
    rd(route_pkg::STATUS_OFFSET, 32'h38);
  endtask : t_pairs
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_trig3();
    t_conv();
    t_pairs();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
